/* File: ssc_pkg.sv */
// Shared constants of the status and control register bank.
// Assumes a serial two-wire link with one-byte register pointers.
package ssc_pkg;

	// ---------------------------------------------------------------
	// Register pointers
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_STATUS     = 8'h00;
	localparam logic [7:0] OFS_PRES_COMP  = 8'h01;
	localparam logic [7:0] OFS_COMP_TEMP  = 8'h02;
	localparam logic [7:0] OFS_RAW_PRES   = 8'h03;
	localparam logic [7:0] OFS_RAW_TEMP   = 8'h04;
	localparam logic [7:0] OFS_ACCESS_KEY = 8'h05;
	localparam logic [7:0] OFS_MV_PRES    = 8'h06;
	localparam logic [7:0] OFS_MV_TEMP    = 8'h07;
	localparam logic [7:0] OFS_DELAY      = 8'h55;
	localparam logic [7:0] OFS_TARE_VALUE = 8'h57;
	localparam logic [7:0] OFS_UNUSED_LO  = 8'hBC;

	// ---------------------------------------------------------------
	// Status field positions
	// ---------------------------------------------------------------
	localparam int unsigned BIT_RST_HI   = 15;
	localparam int unsigned BIT_RST_LO   = 14;
	localparam int unsigned BIT_CLR      = 13;
	localparam int unsigned BIT_TARE     = 12;
	localparam int unsigned BIT_SET_TARE = 11;
	localparam int unsigned BIT_QUE_ERR  = 10;
	localparam int unsigned BIT_INTRLV   = 9;
	localparam int unsigned BIT_AUTO     = 8;
	localparam int unsigned BIT_NV_SAVE  = 5;
	localparam int unsigned BIT_ACTIVE   = 4;
	localparam int unsigned BIT_WR_EN    = 3;
	localparam int unsigned BIT_VALID_HI = 2;
	localparam int unsigned BIT_VALID_LO = 1;
	localparam int unsigned BIT_DONE     = 0;

	// ---------------------------------------------------------------
	// Codes and reset values
	// ---------------------------------------------------------------
	localparam logic [1:0]  RESET_CODE     = 2'h2;
	localparam logic [1:0]  VALID_RST      = 2'h0;
	localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;
	localparam logic [31:0] WORD_UNUSED    = 32'hFFFF_FFFF;
	localparam logic [31:0] DELAY_RST      = 32'h0000_0000;
	localparam logic [6:0]  DEV_ADDR_RST   = 7'h02;
	// Key value is arbitrary
	localparam logic [31:0] ACCESS_KEY_VAL = 32'h0000_5A5A;

endpackage

/* File: ssc_status_ctrl.sv */
// Status and control register bank behind a two-wire serial slave.
// Assumes serial clock on scl_clk, open-drain data split in three signals,
// and a sensor core on clk that supplies results and takes commands.
`timescale 1ns/10ps
module ssc_status_ctrl
	import ssc_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_RST
) (
	// System
	input  wire logic        clk,
	input  wire logic        srst,
	// Serial link
	input  wire logic        scl_clk,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe,
	// Sensor core results
	input  wire logic [31:0] compensated_pressure,
	input  wire logic [31:0] compensated_temperature,
	input  wire logic [31:0] raw_pressure_sample,
	input  wire logic [31:0] raw_temperature_sample,
	input  wire logic [31:0] pressure_millivolts,
	input  wire logic [31:0] temperature_millivolts,
	input  wire logic        converter_active,
	input  wire logic        result_update,
	input  wire logic [1:0]  result_valid,
	input  wire logic        queue_error,
	// Sensor core commands
	output logic             conversion_request,
	output logic             nv_save,
	output logic             full_reset,
	output logic             auto_update,
	output logic             interleave_enable,
	output logic [31:0]      update_delay
);

	if (DEV_ADDR == 7'h00) begin : g_bad_addr
		$error("ssc_status_ctrl: device address must be 1 to 127");
	end

	typedef enum logic [2:0] {
		ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_IGNORE
	} ssc_link_state_t;

	// ---------------------------------------------------------------
	// Link domain and crossings
	// ---------------------------------------------------------------
	logic link_bit_r;
	logic scl_s1_r, scl_s2_r, scl_s3_r;
	logic sda_s1_r, sda_s2_r, sda_s3_r;
	logic lbit_s1_r, lbit_s2_r;

	// Data bit caught on the link's own rising edge, stable while clock is high
	always_ff @(posedge scl_clk) begin
		link_bit_r <= sda_in;
	end

	// Two-flop synchronisers; third stage only for edge detection
	always_ff @(posedge clk) begin
		if (srst) begin
			scl_s1_r  <= 1'b1;
			scl_s2_r  <= 1'b1;
			scl_s3_r  <= 1'b1;
			sda_s1_r  <= 1'b1;
			sda_s2_r  <= 1'b1;
			sda_s3_r  <= 1'b1;
			lbit_s1_r <= 1'b1;
			lbit_s2_r <= 1'b1;
		end else begin
			scl_s1_r  <= scl_clk;
			scl_s2_r  <= scl_s1_r;
			scl_s3_r  <= scl_s2_r;
			sda_s1_r  <= sda_in;
			sda_s2_r  <= sda_s1_r;
			sda_s3_r  <= sda_s2_r;
			lbit_s1_r <= link_bit_r;
			lbit_s2_r <= lbit_s1_r;
		end
	end

	logic ev_start, ev_stop, ev_rise, ev_fall;
	// Bus conditions; bit value comes from the link domain with equal latency
	assign ev_start = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
	assign ev_stop  = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;
	assign ev_rise  = scl_s2_r & ~scl_s3_r;
	assign ev_fall  = ~scl_s2_r & scl_s3_r;

	// ---------------------------------------------------------------
	// Register state
	// ---------------------------------------------------------------
	ssc_link_state_t state_r;
	logic [2:0]  bit_cnt_r;
	logic [1:0]  ack_ph_r;
	logic [7:0]  shift_r;
	logic        rw_r;
	logic        ptr_phase_r;
	logic [7:0]  ptr_r;
	logic [31:0] wbuf_r;
	logic [2:0]  wr_cnt_r;
	logic [31:0] tx_word_r;
	logic [1:0]  tx_idx_r;
	logic [7:0]  tx_sh_r;
	logic        sda_oe_r;
	logic        tare_en_r, interleave_r, auto_r, done_r, queue_err_r, wr_en_r;
	logic [1:0]  valid_r;
	logic [31:0] tare_value_r, delay_r;
	logic        upd_req_r, nv_save_r, full_reset_r;
	logic        rst_all;

	// Full-reset command acts like a power cycle on the bank, except the synchronisers and the one-cycle command flops
	assign rst_all = srst | full_reset_r;

	logic [7:0]  rx_byte;
	logic        commit_wr, rd_load;
	logic [3:0]  be;
	logic [31:0] pres_view, status_word, rd_word;

	assign rx_byte   = {shift_r[6:0], lbit_s2_r};
	// Writes land at stop or repeated start, once per transfer
	assign commit_wr = (ev_start | ev_stop) & (wr_cnt_r != 3'd0);
	assign be        = {wr_cnt_r > 3'd3, wr_cnt_r > 3'd2, wr_cnt_r > 3'd1, wr_cnt_r > 3'd0};
	// Word for a read is fetched when the address acknowledge ends
	assign rd_load   = ev_fall & (state_r == ST_ADDR_ACK) & ack_ph_r[0] & rw_r;

	// Reported pressure, offset removed in tare mode
	assign pres_view = tare_en_r ? compensated_pressure - tare_value_r
		: compensated_pressure;

	// Status word; write-only and reserved positions stay zero
	always_comb begin
		status_word                            = WORD_ZERO;
		status_word[BIT_TARE]                  = tare_en_r;
		status_word[BIT_QUE_ERR]               = queue_err_r;
		status_word[BIT_INTRLV]                = interleave_r;
		status_word[BIT_AUTO]                  = auto_r;
		status_word[BIT_ACTIVE]                = converter_active | interleave_r;
		status_word[BIT_WR_EN]                 = wr_en_r;
		status_word[BIT_VALID_HI:BIT_VALID_LO] = valid_r;
		status_word[BIT_DONE]                  = done_r;
	end

	// Read decode
	always_comb begin
		if (ptr_r == OFS_STATUS) begin
			rd_word = status_word;
		end else if (ptr_r == OFS_PRES_COMP) begin
			rd_word = pres_view;
		end else if (ptr_r == OFS_COMP_TEMP) begin
			rd_word = compensated_temperature;
		end else if (ptr_r == OFS_RAW_PRES) begin
			rd_word = raw_pressure_sample;
		end else if (ptr_r == OFS_RAW_TEMP) begin
			rd_word = raw_temperature_sample;
		end else if (ptr_r == OFS_MV_PRES) begin
			rd_word = pressure_millivolts;
		end else if (ptr_r == OFS_MV_TEMP) begin
			rd_word = temperature_millivolts;
		end else if (ptr_r == OFS_DELAY) begin
			rd_word = delay_r;
		end else if (ptr_r == OFS_TARE_VALUE) begin
			rd_word = tare_value_r;
		end else if (ptr_r >= OFS_UNUSED_LO) begin
			rd_word = WORD_UNUSED;
		end else begin
			rd_word = WORD_ZERO;
		end
	end

	logic result_read;
	// Reads of any result register count, in auto mode only
	assign result_read = rd_load & auto_r & ((ptr_r >= OFS_PRES_COMP && ptr_r <= OFS_RAW_TEMP)
		|| ptr_r == OFS_MV_PRES || ptr_r == OFS_MV_TEMP);

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] en);
		logic [31:0] res;
		res = old_w;
		for (int i = 0; i < 4; i++) begin
			if (en[i]) begin
				res[8*i +: 8] = new_w[8*i +: 8];
			end
		end
		return res;
	endfunction

	// ---------------------------------------------------------------
	// Serial slave sequencer
	// ---------------------------------------------------------------
	// Sda changes only after a falling clock, so hold time is kept
	always_ff @(posedge clk) begin
		if (rst_all) begin
			state_r     <= ST_IDLE;
			bit_cnt_r   <= 3'd0;
			ack_ph_r    <= 2'd0;
			shift_r     <= 8'h00;
			rw_r        <= 1'b0;
			ptr_phase_r <= 1'b0;
			ptr_r       <= OFS_STATUS;
			wbuf_r      <= WORD_ZERO;
			wr_cnt_r    <= 3'd0;
			tx_word_r   <= WORD_ZERO;
			tx_idx_r    <= 2'd0;
			tx_sh_r     <= 8'h00;
			sda_oe_r    <= 1'b0;
		end else if (ev_start | ev_stop) begin
			state_r   <= ev_start ? ST_ADDR : ST_IDLE;
			bit_cnt_r <= 3'd0;
			ack_ph_r  <= 2'd0;
			wr_cnt_r  <= 3'd0;
			sda_oe_r  <= 1'b0;
		end else if (ev_rise) begin
			case (state_r)
				ST_ADDR, ST_RX: begin
					shift_r   <= rx_byte;
					bit_cnt_r <= bit_cnt_r + 3'd1;
					if (bit_cnt_r == 3'd7 && state_r == ST_ADDR) begin
						rw_r    <= rx_byte[0];
						state_r <= (rx_byte[7:1] == DEV_ADDR) ? ST_ADDR_ACK : ST_IGNORE;
					end else if (bit_cnt_r == 3'd7) begin
						state_r <= ST_RX_ACK;
						if (ptr_phase_r) begin
							ptr_r       <= rx_byte;
							ptr_phase_r <= 1'b0;
						end else if (wr_cnt_r < 3'd4) begin
							wbuf_r[8*wr_cnt_r[1:0] +: 8] <= rx_byte;
							wr_cnt_r                     <= wr_cnt_r + 3'd1;
						end
					end
				end
				ST_TX: begin
					bit_cnt_r <= bit_cnt_r + 3'd1;
					if (bit_cnt_r == 3'd7) begin
						state_r  <= ST_TX_ACK;
						ack_ph_r <= 2'd0;
					end
				end
				ST_TX_ACK: begin
					// Master acknowledge low asks for the next byte
					if (ack_ph_r == 2'd1) begin
						ack_ph_r <= 2'd2;
						state_r  <= lbit_s2_r ? ST_IGNORE : ST_TX_ACK;
					end
				end
				default: begin
				end
			endcase
		end else if (ev_fall) begin
			case (state_r)
				ST_ADDR_ACK, ST_RX_ACK: begin
					if (ack_ph_r == 2'd0) begin
						sda_oe_r <= 1'b1;
						ack_ph_r <= 2'd1;
					end else if (rw_r && state_r == ST_ADDR_ACK) begin
						tx_word_r <= rd_word;
						tx_sh_r   <= rd_word[7:0];
						tx_idx_r  <= 2'd1;
						sda_oe_r  <= ~rd_word[7];
						bit_cnt_r <= 3'd0;
						state_r   <= ST_TX;
					end else begin
						if (state_r == ST_ADDR_ACK) begin
							ptr_phase_r <= 1'b1;
						end
						sda_oe_r  <= 1'b0;
						ack_ph_r  <= 2'd0;
						bit_cnt_r <= 3'd0;
						state_r   <= ST_RX;
					end
				end
				ST_TX: begin
					sda_oe_r <= ~tx_sh_r[3'd7 - bit_cnt_r];
				end
				ST_TX_ACK: begin
					if (ack_ph_r == 2'd0) begin
						sda_oe_r <= 1'b0;
						ack_ph_r <= 2'd1;
					end else if (ack_ph_r == 2'd2) begin
						// Bytes go out least significant first
						tx_sh_r   <= tx_word_r[8*tx_idx_r +: 8];
						sda_oe_r  <= ~tx_word_r[8*tx_idx_r + 7];
						tx_idx_r  <= tx_idx_r + 2'd1;
						bit_cnt_r <= 3'd0;
						state_r   <= ST_TX;
					end
				end
				default: begin
					sda_oe_r <= 1'b0;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Status control fields
	// ---------------------------------------------------------------
	logic wr_status;
	assign wr_status = commit_wr & (ptr_r == OFS_STATUS);

	// Mode bits, stored only when their byte is written
	always_ff @(posedge clk) begin
		if (rst_all) begin
			tare_en_r    <= 1'b0;
			interleave_r <= 1'b0;
			auto_r       <= 1'b0;
		end else if (wr_status && be[1]) begin
			tare_en_r    <= wbuf_r[BIT_TARE];
			interleave_r <= wbuf_r[BIT_INTRLV];
			auto_r       <= wbuf_r[BIT_AUTO];
		end
	end

	// Queue error: set beats clear in the same cycle
	always_ff @(posedge clk) begin
		if (rst_all) begin
			queue_err_r <= 1'b0;
		end else if (queue_error && auto_r) begin
			queue_err_r <= 1'b1;
		end else if (wr_status && be[1] && wbuf_r[BIT_CLR]) begin
			queue_err_r <= 1'b0;
		end
	end

	// Done flag: a fresh result wins over any clear
	always_ff @(posedge clk) begin
		if (rst_all) begin
			done_r <= 1'b0;
		end else if (result_update) begin
			done_r <= 1'b1;
		end else if (wr_status && be[1] && wbuf_r[BIT_CLR]) begin
			done_r <= 1'b0;
		end else if (wr_status && be[0]) begin
			done_r <= 1'b0;
		end else if (result_read) begin
			done_r <= 1'b0;
		end
	end

	// Validity follows each new result, cleared by auto-mode reads
	always_ff @(posedge clk) begin
		if (rst_all) begin
			valid_r <= VALID_RST;
		end else if (result_update) begin
			valid_r <= result_valid;
		end else if (result_read) begin
			valid_r <= VALID_RST;
		end
	end

	// Writable flag moves only on access key writes
	always_ff @(posedge clk) begin
		if (rst_all) begin
			wr_en_r <= 1'b0;
		end else if (commit_wr && ptr_r == OFS_ACCESS_KEY) begin
			wr_en_r <= (be == 4'hF) && (wbuf_r == ACCESS_KEY_VAL);
		end
	end

	// Offset and delay words keep all 32 bits, used or not
	always_ff @(posedge clk) begin
		if (rst_all) begin
			tare_value_r <= WORD_ZERO;
			delay_r      <= DELAY_RST;
		end else begin
			if (wr_status && be[1] && wbuf_r[BIT_SET_TARE]) begin
				tare_value_r <= pres_view;
			end else if (commit_wr && ptr_r == OFS_TARE_VALUE) begin
				tare_value_r <= merge_bytes(tare_value_r, wbuf_r, be);
			end
			if (commit_wr && ptr_r == OFS_DELAY) begin
				delay_r <= merge_bytes(delay_r, wbuf_r, be);
			end
		end
	end

	// Reset code decoded early so the same word cannot also issue commands
	logic reset_cmd;
	assign reset_cmd = wr_status & be[1] & (wbuf_r[BIT_RST_HI:BIT_RST_LO] == RESET_CODE);

	// One-cycle commands; nothing is stored for later readback
	always_ff @(posedge clk) begin
		if (srst) begin
			full_reset_r <= 1'b0;
			upd_req_r    <= 1'b0;
			nv_save_r    <= 1'b0;
		end else begin
			full_reset_r <= reset_cmd;
			upd_req_r    <= wr_status & be[0] & wbuf_r[BIT_DONE] & ~reset_cmd;
			nv_save_r    <= wr_status & be[0] & wbuf_r[BIT_NV_SAVE] & wr_en_r
				& ~reset_cmd;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	assign sda_out            = 1'b0;
	assign sda_oe             = sda_oe_r;
	assign conversion_request = upd_req_r;
	assign nv_save            = nv_save_r;
	assign full_reset         = full_reset_r;
	assign auto_update        = auto_r;
	assign interleave_enable  = interleave_r;
	assign update_delay       = delay_r;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst_all);

	chk_reserved_zero: assert property (
		status_word[31:13] == 19'h0 && !status_word[BIT_SET_TARE] && status_word[7:5] == 3'h0)
		else $error("reserved or write-only status bit reads nonzero");
	chk_reset_code: assert property (
		disable iff (srst)
		wr_status && be[1]
		|=> full_reset_r == ($past(wbuf_r[BIT_RST_HI:BIT_RST_LO]) == RESET_CODE))
		else $error("reset command decode wrong");
	chk_clear_flags: assert property (
		wr_status && be[1] && wbuf_r[BIT_CLR] && !result_update && !queue_error
		|=> !done_r && !queue_err_r)
		else $error("clear strobe left a flag set");
	chk_tare_copy: assert property (
		wr_status && be[1] && wbuf_r[BIT_SET_TARE] |=> tare_value_r == $past(pres_view))
		else $error("offset copy missed");
	chk_queue_sticky: assert property (
		queue_err_r && !(wr_status && be[1] && wbuf_r[BIT_CLR]) && !full_reset_r
		|=> queue_err_r)
		else $error("queue error dropped without strobe");
	chk_active_bit: assert property (
		status_word[BIT_ACTIVE] == (interleave_r || converter_active))
		else $error("converter active bit wrong");
	chk_nv_guard: assert property (
		nv_save_r |-> $past(wr_en_r) && $past(wbuf_r[BIT_NV_SAVE]))
		else $error("save issued while not writable");
	chk_writable_hold: assert property (
		!(commit_wr && ptr_r == OFS_ACCESS_KEY) && !full_reset_r |=> $stable(wr_en_r))
		else $error("writable flag moved without key write");
	chk_valid_load: assert property (
		result_update |=> valid_r == $past(result_valid) && done_r)
		else $error("validity not loaded from result");
	chk_read_clear: assert property (
		result_read && !result_update |=> valid_r == 2'h0 && !done_r)
		else $error("auto-mode read did not clear flags");
	chk_update_request: assert property (
		wr_status && be[0] && wbuf_r[BIT_DONE] |=> conversion_request ##1 !conversion_request)
		else $error("update request not a single pulse");

	cov_request: cover property (wr_status && be[0] && wbuf_r[BIT_DONE] ##[1:1000] result_update);
	cov_auto_read: cover property (result_read);
	cov_tare_copy: cover property (wr_status && be[1] && wbuf_r[BIT_SET_TARE]);
	cov_full_reset: cover property (disable iff (srst) full_reset_r);

endmodule

/* File: ssc_i2c_master.sv */
// Behavioural two-wire bus master for the status bank link.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/10ps
module ssc_i2c_master
	import ssc_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = DEV_ADDR_RST
) (
	// Link
	output logic      scl_clk,
	output logic      sda_low,
	input  wire logic sda_in
);
	// ---------------------------------------------------------------
	// Bit and frame timing, 32 ns per bit
	// ---------------------------------------------------------------
	logic ack_ok;

	// Clock stands high and data is released between frames
	initial begin
		scl_clk = 1'b1;
		sda_low = 1'b0;
		ack_ok  = 1'b1;
	end

	// Data moves mid-low, sampled late in the high phase
	task automatic xbit(input logic b, output logic s);
		#8 sda_low = ~b;
		#8 scl_clk = 1'b1;
		#14 s = sda_in;
		#2 scl_clk = 1'b0;
	endtask

	// Start or repeated start: data falls while clock high
	task automatic start();
		#8 sda_low = 1'b0;
		#8 scl_clk = 1'b1;
		#16 sda_low = 1'b1;
		#16 scl_clk = 1'b0;
	endtask

	task automatic stop();
		#8 sda_low = 1'b1;
		#8 scl_clk = 1'b1;
		#16 sda_low = 1'b0;
		#16;
	endtask

	// Byte out most significant bit first, then take the acknowledge
	task automatic send_byte(input logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) xbit(d[i], s);
		xbit(1'b1, s);
		if (s !== 1'b0) ack_ok = 1'b0;
	endtask

	// Last byte is refused so the slave lets go of the wire
	task automatic get_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
		xbit(last, s);
	endtask

	// Pointer byte, then n data bytes least significant first
	task automatic write_reg(input logic [7:0] p, input logic [31:0] d, input int n,
		output logic ok);
		ack_ok = 1'b1;
		start();
		send_byte({DEV_ADDR, 1'b0});
		send_byte(p);
		for (int k = 0; k < n; k++) send_byte(d[8*k +: 8]);
		stop();
		ok = ack_ok;
	endtask

	// Pointer write, repeated start, four bytes back
	task automatic read_reg(input logic [7:0] p, output logic [31:0] d);
		ack_ok = 1'b1;
		start();
		send_byte({DEV_ADDR, 1'b0});
		send_byte(p);
		start();
		send_byte({DEV_ADDR, 1'b1});
		for (int k = 0; k < 4; k++) get_byte(k == 3, d[8*k +: 8]);
		stop();
	endtask
endmodule

/* File: tb_top.sv */
// Self-checking bench for the status and control register bank.
// Assumes the bus master model drives the link; core inputs come from here.
`timescale 1ns/10ps
module tb_top;
	import ssc_pkg::*;
	// ---------------------------------------------------------------
	// Signals and counters
	// ---------------------------------------------------------------
	logic        clk, srst, scl_clk, sda_low, sda_in, sda_out, sda_oe;
	logic [31:0] cpres, ctemp, rpres, rtemp, mvp, mvt, update_delay;
	logic        core_act, res_upd, fault_in, upd_req, nv_save, full_reset;
	logic        auto_update, interleave_enable;
	logic [1:0]  res_valid;
	logic [7:0]  ptrs [6];
	int          miscompares, tests_run, n_req, n_nv, n_rst;

	always #2 clk = ~clk;
	// Open-drain wire with pull-up
	assign sda_in = ~(sda_low | sda_oe);

	ssc_status_ctrl DUT (.clk(clk), .srst(srst), .scl_clk(scl_clk), .sda_in(sda_in),
		.sda_out(sda_out), .sda_oe(sda_oe), .compensated_pressure(cpres),
		.compensated_temperature(ctemp), .raw_pressure_sample(rpres),
		.raw_temperature_sample(rtemp), .pressure_millivolts(mvp),
		.temperature_millivolts(mvt), .converter_active(core_act), .result_update(res_upd),
		.result_valid(res_valid), .queue_error(fault_in), .conversion_request(upd_req),
		.nv_save(nv_save), .full_reset(full_reset), .auto_update(auto_update),
		.interleave_enable(interleave_enable), .update_delay(update_delay));
	ssc_i2c_master u_master (.scl_clk(scl_clk), .sda_low(sda_low), .sda_in(sda_in));

	// Command pulses counted so missing or extra ones show up
	always @(posedge clk) begin
		if (upd_req === 1'b1) n_req++;
		if (nv_save === 1'b1) n_nv++;
		if (full_reset === 1'b1) n_rst++;
	end

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] p, input logic [31:0] d, input int n);
		logic ok;
		@(posedge clk);
		#1;
		u_master.write_reg(p, d, n, ok);
		check("write ack", 32'h0000_0001, {31'h0, ok});
		repeat (4) @(posedge clk);
	endtask

	task automatic rd(input logic [7:0] p, input logic [31:0] exp, input string name);
		logic [31:0] got;
		@(posedge clk);
		#1;
		u_master.read_reg(p, got);
		check(name, exp, got);
		repeat (4) @(posedge clk);
	endtask

	// One-cycle core event: result update with validity, or queue error
	task automatic pulse(input logic q, input logic [1:0] v);
		@(posedge clk);
		res_upd <= ~q;
		fault_in <= q;
		res_valid <= v;
		@(posedge clk);
		res_upd <= 1'b0;
		fault_in <= 1'b0;
	endtask

	task automatic complete_run();
		if (miscompares == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_fields();
		rd(OFS_STATUS, 32'h0000_0000, "status reset");
		wr(OFS_STATUS, 32'hFFFF_F7FE, 4);
		rd(OFS_STATUS, 32'h0000_1310, "status rw");
		check("modes", 32'h3, {auto_update, interleave_enable});
		wr(OFS_STATUS, 32'h0000_4300, 2);
		wr(OFS_STATUS, 32'h0000_0000, 1);
		rd(OFS_STATUS, 32'h0000_0310, "byte merge");
		check("reset pulses", 0, n_rst);
		check("save pulses", 0, n_nv);
		wr(OFS_STATUS, 32'h0000_0000, 2);
	endtask

	task automatic t_conversion_done();
		wr(OFS_STATUS, 32'h0000_0001, 1);
		check("requests", 1, n_req);
		rd(OFS_STATUS, 32'h0000_0000, "not done");
		for (int v = 0; v < 4; v++) begin
			pulse(1'b0, v[1:0]);
			rd(OFS_STATUS, {29'h0, v[1:0], 1'b1}, "valid code");
		end
		wr(OFS_STATUS, 32'h0000_0000, 1);
		rd(OFS_STATUS, 32'h0000_0006, "done by zero");
		pulse(1'b0, 2'b11);
		wr(OFS_STATUS, 32'h0000_2001, 2);
		rd(OFS_STATUS, 32'h0000_0006, "done by strobe");
	endtask

	task automatic t_auto();
		logic [31:0] res [6];
		res = '{cpres, ctemp, rpres, rtemp, mvp, mvt};
		pulse(1'b1, 2'b00);
		wr(OFS_STATUS, 32'h0000_0100, 2);
		rd(OFS_STATUS, 32'h0000_0106, "queue err auto off");
		pulse(1'b1, 2'b00);
		rd(OFS_STATUS, 32'h0000_0506, "queue err set");
		for (int i = 0; i < 6; i++) begin
			pulse(1'b0, 2'b11);
			rd(ptrs[i], res[i], "result");
			rd(OFS_STATUS, 32'h0000_0500, "auto read clear");
		end
		wr(OFS_STATUS, 32'h0000_2100, 2);
		rd(OFS_STATUS, 32'h0000_0100, "queue err cleared");
		wr(OFS_STATUS, 32'h0000_0000, 2);
		pulse(1'b0, 2'b11);
		rd(OFS_COMP_TEMP, ctemp, "manual read");
		rd(OFS_STATUS, 32'h0000_0007, "manual keeps");
	endtask

	task automatic t_tare();
		wr(OFS_STATUS, 32'h0000_0800, 2);
		rd(OFS_TARE_VALUE, 32'h0000_03E8, "offset copy");
		wr(OFS_STATUS, 32'h0000_1000, 2);
		cpres <= 32'h0000_05DC;
		rd(OFS_PRES_COMP, 32'h0000_01F4, "tare on");
		wr(OFS_STATUS, 32'h0000_0000, 2);
		rd(OFS_PRES_COMP, 32'h0000_05DC, "tare off");
	endtask

	task automatic t_key();
		wr(OFS_STATUS, 32'h0000_0020, 1);
		check("save locked", 0, n_nv);
		wr(OFS_ACCESS_KEY, ACCESS_KEY_VAL, 4);
		rd(OFS_STATUS, 32'h0000_000E, "writable");
		wr(OFS_STATUS, 32'h0000_0020, 1);
		check("save open", 1, n_nv);
		wr(OFS_ACCESS_KEY, WORD_ZERO, 4);
		rd(OFS_STATUS, 32'h0000_0006, "locked");
	endtask

	task automatic t_misc();
		core_act <= 1'b1;
		rd(OFS_STATUS, 32'h0000_0016, "active");
		core_act <= 1'b0;
		wr(OFS_DELAY, 32'h1234_5678, 4);
		rd(OFS_DELAY, 32'h1234_5678, "delay");
		check("delay out", 32'h1234_5678, update_delay);
		check("sda level", 32'h0000_0000, {31'h0, sda_out});
		rd(OFS_UNUSED_LO, WORD_UNUSED, "unused");
		wr(OFS_STATUS, 32'h0000_8001, 2);
		check("reset pulses", 1, n_rst);
		check("request with reset", 2, n_req);
		rd(OFS_STATUS, 32'h0000_0000, "after reset");
		check("delay reset", 0, update_delay);
	endtask

	// Watchdog cuts a hang short
	initial begin
		#300000;
		miscompares++;
		complete_run();
	end

	// Main sequence
	initial begin
		clk = 1'b0;
		srst = 1'b1;
		{core_act, res_upd, fault_in, res_valid} = '0;
		{cpres, ctemp, rpres, rtemp} = {32'h0000_03E8, 32'h0000_0019, 32'h0001_2345, 32'h0000_6789};
		{mvp, mvt} = {32'h0000_00AB, 32'h0000_00CD};
		ptrs = '{OFS_PRES_COMP, OFS_COMP_TEMP, OFS_RAW_PRES, OFS_RAW_TEMP, OFS_MV_PRES, OFS_MV_TEMP};
		{miscompares, tests_run, n_req, n_nv, n_rst} = '0;
		repeat (8) @(posedge clk);
		srst <= 1'b0;
		repeat (4) @(posedge clk);
		t_fields();
		t_conversion_done();
		t_auto();
		t_tare();
		t_key();
		t_misc();
		complete_run();
	end
endmodule
